// ==== logic/dsr_rx_ctl.sv ====
// Purpose: receive error enables, format control and clear-on-read status
// Assumes: event inputs are one-cycle pulses from logic on ref_clk
// Notes:   sync inputs are active high; polarity applied on output
`timescale 1ns/1ps
module dsr_rx_ctl (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   sys_rst,
	// register port
	input  wire logic [dsr_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [dsr_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [dsr_pkg::DATA_W-1:0] reg_rdata,
	// error source pulses, bit order as the enable registers
	input  wire logic [dsr_pkg::N_SRC_A-1:0] err_src_a,
	input  wire logic [dsr_pkg::N_SRC_B-1:0] err_src_b,
	input  wire logic                   null_blank_crc_err,
	input  wire logic                   wc_filter_err,
	// link events
	input  wire logic                   hs_end,
	input  wire logic                   hs_end_had_eot,
	input  wire logic                   xfifo_overflow,
	input  wire logic                   xfifo_rd,
	input  wire logic                   xfifo_empty,
	input  wire logic                   link_buf_overflow,
	// timing
	input  wire logic                   vsync_in,
	input  wire logic                   hsync_in,
	output logic                        vsync_out,
	output logic                        hsync_out,
	// pixels
	input  wire logic [23:0]            pix_in,
	input  wire logic                   pix_in_vld,
	input  wire logic [3:0]             pix_sub_bits,
	output logic      [23:0]            pix_out,
	output logic                        pix_out_vld,
	// status
	output logic                        any_error_out,
	output logic                        wc_filter_en
);
	typedef struct packed {
		logic [7:0] fmt;
		logic [7:0] en_a;
		logic [7:0] en_b;
		logic [7:0] status;
		logic [7:0] err_cnt;
		logic [7:0] rdata;
		logic       vs;
		logic       hs;
		logic       err_out;
		logic       filt_en;
	} dsr_ctl_s;

	dsr_ctl_s st_q;
	dsr_ctl_s st_d;

	logic       rd_status;
	logic       rd_count;
	logic       eot_miss;
	logic       crc_ev;
	logic       any_ev;
	logic [7:0] rd_mux;

	always_comb begin
		rd_status = reg_rd && (reg_addr == dsr_pkg::OFS_STATUS);
		rd_count  = reg_rd && (reg_addr == dsr_pkg::OFS_ERR_COUNT);
		// missing EOT only counts while EOT packets are mandatory
		eot_miss  = hs_end && !hs_end_had_eot && !st_q.fmt[dsr_pkg::FMT_EOT_OPT];
		// null/blank checksum errors join the checksum source while reporting is on
		crc_ev    = null_blank_crc_err && st_q.fmt[dsr_pkg::FMT_NULL_CRC];
		// invalid-vc source passes only through its enable; packets are never dropped here
		any_ev    = |(err_src_a & st_q.en_a)
			| |({err_src_b[6:2], err_src_b[1] | crc_ev, err_src_b[0]} & st_q.en_b[6:0])
			| (eot_miss && st_q.en_b[6]);
		unique case (reg_addr)
			dsr_pkg::OFS_FMT_CTL:   rd_mux = st_q.fmt;
			dsr_pkg::OFS_ERR_EN_A:  rd_mux = st_q.en_a;
			dsr_pkg::OFS_ERR_EN_B:  rd_mux = st_q.en_b;
			dsr_pkg::OFS_STATUS:    rd_mux = st_q.status;
			dsr_pkg::OFS_ERR_COUNT: rd_mux = st_q.err_cnt;
			default:                rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		st_d = st_q;
		st_d.rdata = reg_rd ? rd_mux : 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				dsr_pkg::OFS_FMT_CTL:   st_d.fmt  = reg_wdata & dsr_pkg::MASK_FMT_CTL;
				dsr_pkg::OFS_ERR_EN_A:  st_d.en_a = reg_wdata;
				dsr_pkg::OFS_ERR_EN_B:  st_d.en_b = reg_wdata & dsr_pkg::MASK_ERR_EN_B;
				dsr_pkg::OFS_ERR_COUNT: st_d.err_cnt = reg_wdata;
				default: ;
			endcase
		end
		// clear on read first, then new events win
		if (rd_status)
			st_d.status = 8'h00;
		if (xfifo_overflow)
			st_d.status[dsr_pkg::ST_FIFO_OVF] = 1'b1;
		if (xfifo_rd && xfifo_empty)
			st_d.status[dsr_pkg::ST_FIFO_UNF] = 1'b1;
		if (link_buf_overflow)
			st_d.status[dsr_pkg::ST_LINK_BUF] = 1'b1;
		if (eot_miss)
			st_d.status[dsr_pkg::ST_EOT_MISS] = 1'b1;
		if (any_ev)
			st_d.status[dsr_pkg::ST_ERR_DET] = 1'b1;
		// no command mode, so these never set
		st_d.status[dsr_pkg::ST_CMD_OVF] = 1'b0;
		st_d.status[dsr_pkg::ST_RD_NO_TA] = 1'b0;
		st_d.status[7] = 1'b0;
		// counter: read clears, a coincident event restarts at one; saturates
		if (rd_count)
			st_d.err_cnt = any_ev ? 8'h01 : 8'h00;
		else if (any_ev && st_q.err_cnt != 8'hFF)
			st_d.err_cnt = st_q.err_cnt + 8'h01;
		// held mode shows the sticky flag, pulse mode shows the event itself
		if (st_q.fmt[dsr_pkg::FMT_HOLD_ERR])
			st_d.err_out = st_d.status[dsr_pkg::ST_ERR_DET];
		else
			st_d.err_out = any_ev;
		st_d.vs      = vsync_in ^ st_q.fmt[dsr_pkg::FMT_VS_POL];
		st_d.hs      = hsync_in ^ st_q.fmt[dsr_pkg::FMT_HS_POL];
		st_d.filt_en = !st_q.fmt[dsr_pkg::FMT_NO_FILTER];
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q         <= '0;
			st_q.fmt     <= dsr_pkg::RST_FMT_CTL;
			st_q.en_a    <= dsr_pkg::RST_ERR_EN_A;
			st_q.en_b    <= dsr_pkg::RST_ERR_EN_B;
			st_q.filt_en <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// wc_filter_err is consumed by the source logic via wc_filter_en; tied to an unused net here, not reported
	logic unused_filt;
	assign unused_filt = wc_filter_err;

	dsr_pix_expand u_pix (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.gray_dis    (st_q.fmt[dsr_pkg::FMT_NO_GRAY]),
		.sub_bits    (pix_sub_bits),
		.pix_in      (pix_in),
		.pix_in_vld  (pix_in_vld),
		.pix_out     (pix_out),
		.pix_out_vld (pix_out_vld)
	);

	assign reg_rdata     = st_q.rdata;
	assign vsync_out     = st_q.vs;
	assign hsync_out     = st_q.hs;
	assign any_error_out = st_q.err_out;
	assign wc_filter_en  = st_q.filt_en;
endmodule : dsr_rx_ctl

// ==== logic/dsr_pkg.sv ====
// Purpose: shared constants for the receive error/status register bank
// Assumes: 8-bit registers on a plain address/strobe port
// Notes:   offsets are register indices on the 8-bit port
package dsr_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam logic [7:0]  OFS_FMT_CTL     = 8'h21;
	localparam logic [7:0]  OFS_ERR_EN_A    = 8'h22;
	localparam logic [7:0]  OFS_ERR_EN_B    = 8'h23;
	localparam logic [7:0]  OFS_STATUS      = 8'h28;
	localparam logic [7:0]  OFS_ERR_COUNT   = 8'h29;
	localparam logic [7:0]  RST_FMT_CTL     = 8'h00;
	localparam logic [7:0]  RST_ERR_EN_A    = 8'hFF;
	localparam logic [7:0]  RST_ERR_EN_B    = 8'h7F;
	localparam logic [7:0]  MASK_ERR_EN_B   = 8'h7F;
	localparam logic [7:0]  MASK_FMT_CTL    = 8'hFB;
	// input_format_control fields
	localparam int          FMT_NO_GRAY     = 7;
	localparam int          FMT_VS_POL      = 6;
	localparam int          FMT_HS_POL      = 5;
	localparam int          FMT_HOLD_ERR    = 4;
	localparam int          FMT_NULL_CRC    = 3;
	localparam int          FMT_NO_FILTER   = 1;
	localparam int          FMT_EOT_OPT     = 0;
	// receive_status_flags fields
	localparam int          ST_FIFO_OVF     = 6;
	localparam int          ST_FIFO_UNF     = 5;
	localparam int          ST_LINK_BUF     = 4;
	localparam int          ST_CMD_OVF      = 3;
	localparam int          ST_EOT_MISS     = 2;
	localparam int          ST_RD_NO_TA     = 1;
	localparam int          ST_ERR_DET      = 0;
	localparam int          N_SRC_A         = 8;
	localparam int          N_SRC_B         = 7;
endpackage : dsr_pkg

// ==== logic/dsr_pix_expand.sv ====
// Purpose: expand narrow RGB subpixels to 8 bits
// Assumes: input subpixels are left aligned in 8 bits, low bits zero
// Notes:   registered output, one cycle latency
`timescale 1ns/1ps
module dsr_pix_expand (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// control
	input  wire logic        gray_dis,
	input  wire logic [3:0]  sub_bits,
	// pixel
	input  wire logic [23:0] pix_in,
	input  wire logic        pix_in_vld,
	output logic      [23:0] pix_out,
	output logic             pix_out_vld
);
	typedef struct packed {
		logic [23:0] pix;
		logic        vld;
	} dsr_pe_s;

	dsr_pe_s st_q;
	dsr_pe_s st_d;

	// replicate top bits into the unused low bits of one subpixel
	function automatic logic [7:0] dsr_rep(input logic [7:0] v, input logic [3:0] n);
		logic [15:0] two;
		two = {v, v} >> n;
		if (n >= 4'h8 || n == 4'h0)
			dsr_rep = v;
		else
			dsr_rep = v | (two[7:0] & ~(8'hFF << (4'h8 - n)));
	endfunction : dsr_rep

	always_comb begin
		st_d     = st_q;
		st_d.vld = pix_in_vld;
		if (pix_in_vld) begin
			if (gray_dis)
				st_d.pix = pix_in;
			else
				st_d.pix = {dsr_rep(pix_in[23:16], sub_bits), dsr_rep(pix_in[15:8], sub_bits),
					dsr_rep(pix_in[7:0], sub_bits)};
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign pix_out     = st_q.pix;
	assign pix_out_vld = st_q.vld;
endmodule : dsr_pix_expand

// ==== testbench/dsr_rx_chk.sv ====
// Purpose: port assertions for the receive control bank
// Assumes: bound onto dsr_rx_ctl, one ref_clk domain
// Notes:   format and first error enable registers are shadowed from observed writes
`timescale 1ns/1ps
module dsr_rx_chk (
	// clock, reset and register port
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// events and outputs
	input wire logic [7:0] err_src_a,
	input wire logic       hs_end,
	input wire logic       hs_end_had_eot,
	input wire logic       xfifo_overflow,
	input wire logic       vsync_in,
	input wire logic       hsync_in,
	input wire logic       vsync_out,
	input wire logic       hsync_out,
	input wire logic       any_error_out,
	input wire logic       wc_filter_en
);
	logic [7:0] fmt_q, ena_q;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) {fmt_q, ena_q} <= 16'h00FF;
		else if (reg_wr && reg_addr == 8'h21) fmt_q <= reg_wdata;
		else if (reg_wr && reg_addr == 8'h22) ena_q <= reg_wdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_st_rd; reg_rd && reg_addr == 8'h28; endsequence
	property p_vpol; vsync_out == ($past(vsync_in) ^ $past(fmt_q[6])); endproperty
	a_vpol: assert property (p_vpol) else $error("vsync polarity wrong");
	property p_hpol; hsync_out == ($past(hsync_in) ^ $past(fmt_q[5])); endproperty
	a_hpol: assert property (p_hpol) else $error("hsync polarity wrong");
	property p_filt; wc_filter_en == !$past(fmt_q[1]); endproperty
	a_filt: assert property (p_filt) else $error("filter enable wrong");
	property p_pulse; (err_src_a & ena_q) != 8'h00 |=> any_error_out; endproperty
	a_pulse: assert property (p_pulse) else $error("enabled error not shown");
	// a read one cycle back has already cleared the aggregate by this cycle
	property p_hold; fmt_q[4] && any_error_out && !reg_rd && !$past(reg_rd) && !reg_wr
		|=> any_error_out; endproperty
	a_hold: assert property (p_hold) else $error("held error dropped");
	property p_eot; hs_end && !hs_end_had_eot && !fmt_q[0] ##1 !reg_rd ##1 s_st_rd
		|=> reg_rdata[2]; endproperty
	a_eot: assert property (p_eot) else $error("missing eot not flagged");
	property p_ovf; xfifo_overflow ##1 !reg_rd ##1 s_st_rd |=> reg_rdata[6]; endproperty
	a_ovf: assert property (p_ovf) else $error("fifo overflow not flagged");
	property p_cmd; s_st_rd |=> !reg_rdata[3] && !reg_rdata[1]; endproperty
	a_cmd: assert property (p_cmd) else $error("command flags not zero");
endmodule : dsr_rx_chk

// ==== testbench/dsr_host_model.sv ====
// Purpose: display host stand-in raising receive error events
// Assumes: one event per request, each one cycle long
// Notes:   eot qualifier wanders outside events so stale levels are not trusted
`timescale 1ns/1ps
module dsr_host_model (
	// request from the bench
	input  wire logic       ref_clk,
	input  wire logic       go,
	input  wire logic [4:0] ev,
	// events toward the receiver
	output logic      [7:0] err_src_a,
	output logic      [6:0] err_src_b,
	output logic            hs_end,
	output logic            hs_end_had_eot
);
	logic       g_q = 1'b0;
	logic [4:0] e_q = 5'h00;
	always @(posedge ref_clk) begin
		g_q <= go;
		e_q <= ev;
	end
	// codes 0-14 pick a source bit, 16 and 17 end a burst without and with eot
	assign err_src_a = (g_q && e_q[4:3] == 2'h0) ? 8'h01 << e_q[2:0] : 8'h00;
	assign err_src_b = (g_q && e_q[4:3] == 2'h1 && e_q[2:0] != 3'h7) ? 7'h01 << e_q[2:0] : 7'h00;
	assign hs_end = g_q && e_q[4:1] == 4'h8;
	assign hs_end_had_eot = g_q ? e_q[0] : ~e_q[0];
endmodule : dsr_host_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the receive control bank
// Assumes: every task starts just after a rising edge
// Notes:   short run, no long counts involved
`timescale 1ns/1ps
module tb;
	logic        ref_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        vsync_in = 1'b0, hsync_in = 1'b0, pix_in_vld = 1'b0, wc_filter_err = 1'b0;
	logic        vsync_out, hsync_out, pix_out_vld, any_error_out, wc_filter_en;
	logic        hs_end, hs_end_had_eot, null_blank_crc_err, link_buf_overflow;
	logic        xfifo_overflow, xfifo_rd, xfifo_empty;
	logic [4:0]  ev = 5'h00, tb_ev = 5'h00;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, err_src_a;
	logic [6:0]  err_src_b;
	logic [3:0]  pix_sub_bits = 4'h5;
	logic [23:0] pix_in = 24'hA8A8A8, pix_out;
	int          err_total = 0, checks = 0;
	assign {null_blank_crc_err, xfifo_overflow, xfifo_rd, xfifo_empty, link_buf_overflow} = tb_ev;
	dsr_rx_ctl i_dsr_rx_ctl (.*);
	dsr_host_model i_dsr_host_model (.*);
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic wrap_up;
		if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		checks++;
		err_total += (s !== e);
		if (s !== e) $display("MISMATCH %s expected %h seen %h", n, e, s);
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask : wr
	task automatic rc(logic [7:0] a, logic [7:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk) reg_rd <= 1'b0;
		@(negedge ref_clk) chk("reg_rdata", reg_rdata, e);
		@(posedge ref_clk);
	endtask : rc
	// host event n and bench pulses m land together; x is the aggregate expected after
	task automatic evt(logic [4:0] n, logic [4:0] m, logic x);
		go <= 1'b1;
		ev <= n;
		@(posedge ref_clk) go <= 1'b0;
		tb_ev <= m;
		@(posedge ref_clk) tb_ev <= 5'h00;
		@(negedge ref_clk) chk("any_error_out", any_error_out, x);
		@(posedge ref_clk);
	endtask : evt
	task automatic t_regs;
		rc(8'h21, 8'h00);
		rc(8'h22, 8'hFF);
		rc(8'h23, 8'h7F);
		chk("wc_filter_en", wc_filter_en, 1'b1);
		wr(8'h23, 8'hF7);
		rc(8'h23, 8'h77);
		evt(5'd11, 5'h00, 1'b0);
		wr(8'h28, 8'hFF);
		rc(8'h28, 8'h00);
		rc(8'h29, 8'h00);
		rc(8'h40, 8'h00);
		wr(8'h23, 8'h7F);
	endtask : t_regs
	task automatic t_src;
		for (int i = 0; i < 15; i++) begin
			evt(5'(i), 5'h00, 1'b1);
			rc(8'h28, 8'h01);
		end
		rc(8'h29, 8'h0F);
		rc(8'h29, 8'h00);
		wr(8'h22, 8'hFE);
		evt(5'd0, 5'h00, 1'b0);
		wr(8'h22, 8'hFF);
	endtask : t_src
	task automatic t_status;
		evt(5'd16, 5'h00, 1'b1);
		rc(8'h28, 8'h05);
		evt(5'd17, 5'h00, 1'b0);
		evt(5'd31, 5'h08, 1'b0);
		rc(8'h28, 8'h40);
		evt(5'd31, 5'h06, 1'b0);
		rc(8'h28, 8'h20);
		evt(5'd31, 5'h01, 1'b0);
		rc(8'h28, 8'h10);
		wr(8'h21, 8'h08);
		evt(5'd31, 5'h10, 1'b1);
		rc(8'h28, 8'h01);
		wr(8'h21, 8'h00);
	endtask : t_status
	task automatic t_ctl;
		wr(8'h21, 8'h73);
		vsync_in <= 1'b1;
		evt(5'd16, 5'h10, 1'b0);
		@(negedge ref_clk) chk("vsync_out", vsync_out, 1'b0);
		chk("hsync_out", hsync_out, 1'b1);
		chk("wc_filter_en", wc_filter_en, 1'b0);
		@(posedge ref_clk) evt(5'd1, 5'h00, 1'b1);
		repeat (3) @(negedge ref_clk);
		chk("any_error_out", any_error_out, 1'b1);
		@(posedge ref_clk) rc(8'h28, 8'h01);
		@(negedge ref_clk) chk("any_error_out", any_error_out, 1'b0);
		@(posedge ref_clk) wr(8'h21, 8'h00);
		pix_in_vld <= 1'b1;
		@(posedge ref_clk) pix_in_vld <= 1'b0;
		@(negedge ref_clk) chk("pix_out", pix_out, 24'hADADAD);
		chk("pix_out_vld", pix_out_vld, 1'b1);
		@(posedge ref_clk) wr(8'h21, 8'h80);
		pix_in_vld <= 1'b1;
		@(posedge ref_clk) pix_in_vld <= 1'b0;
		@(negedge ref_clk) chk("pix_out", pix_out, 24'hA8A8A8);
	endtask : t_ctl
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_src();
		t_status();
		t_ctl();
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		wrap_up();
	end
endmodule : tb
bind dsr_rx_ctl dsr_rx_chk i_dsr_rx_chk (.*);
